/* hw/register_stack_16x4.sv */
// Contract
// RULE1 - sixteen four-bit words, four-bit address
// RULE2 - write when write, select, clock low
// RULE3 - write is transparent while all three low
// RULE4 - clock rise with select low loads output
// RULE5 - output register changes only on rise
// RULE6 - writes proceed while output holds old word
// RULE7 - enable high floats outputs, low drives them
// RULE8 - select high blocks writes and loads
`timescale 1ns/10ps
`default_nettype none
`include "register_stack_params.svh"

module register_stack_16x4
	import register_stack_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// address and data pins
	input wire logic [`RS_ADDR_WIDTH-1:0] word_address_i,
	input wire logic [`RS_WORD_WIDTH-1:0] write_data_in_i,
	// control pins
	input wire logic chip_select_n_i,
	input wire logic write_enable_n_i,
	input wire logic clock_pulse_in_i,
	input wire logic output_drive_enable_n_i,
	// three-state data outputs
	output logic [`RS_WORD_WIDTH-1:0] read_data_out_o,
	output logic [`RS_WORD_WIDTH-1:0] read_data_oe_o
);

	// raw pin bundle and its two-flop copy
	logic [`RS_PIN_COUNT-1:0] raw_pins;
	logic [`RS_PIN_COUNT-1:0] synced;

	// synchronised pin fields
	addr_type address;
	word_type data_in;
	logic select_n;
	logic write_n;
	logic cp;
	logic drive_n;

	// decoded strobes
	logic selected;
	logic write_ok;
	logic cp_low;
	logic write_now;
	logic cp_rise;
	logic load_now;

	// per-word address decode and write strobes
	logic [`RS_WORD_COUNT-1:0] word_hit;
	logic [`RS_WORD_COUNT-1:0] word_write;

	// per-word contents after this cycle's write
	word_type [`RS_WORD_COUNT-1:0] words_after;

	// read path: each word masked by its hit, then or-folded
	word_type [`RS_WORD_COUNT-1:0] word_masked;
	word_type [`RS_WORD_COUNT:0] read_fold;
	word_type read_word;

	// per-bit drive enables
	logic [`RS_WORD_WIDTH-1:0] drive_bits;

	// registered state and its next value
	stack_state_type state;
	stack_state_type next_state;

	// every pin shares one delay, so address and strobes stay aligned
	assign raw_pins = {
		word_address_i,
		write_data_in_i,
		chip_select_n_i,
		write_enable_n_i,
		clock_pulse_in_i,
		output_drive_enable_n_i
	};

	pin_sync u_pin_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pins_i(raw_pins),
		.pins_o(synced)
	);

	// field positions must match the bundle order above
	assign address = synced[`RS_PIN_ADDR_LSB +: `RS_ADDR_WIDTH];
	assign data_in = synced[`RS_PIN_DATA_LSB +: `RS_WORD_WIDTH];
	assign select_n = synced[`RS_PIN_SELECT];
	assign write_n = synced[`RS_PIN_WRITE];
	assign cp = synced[`RS_PIN_CLOCK];
	assign drive_n = synced[`RS_PIN_DRIVE];

	// pin clock is sampled as data; its pulses must be slow against clk_i
	assign selected = !select_n;
	assign write_ok = !write_n;
	assign cp_low = !cp;

	// level write, re-applied each cycle all three stay low
	assign write_now = write_ok && selected && cp_low; // RULE2 RULE3 RULE8

	// cp_prev resets low, matching the idle level of the pin clock
	assign cp_rise = cp && !state.cp_prev;
	assign load_now = cp_rise && selected; // RULE4 RULE8

	// one decoder and one writer per word
	generate
		for (genvar i = 0; i < `RS_WORD_COUNT; i++) begin : g_word
			assign word_hit[i] = (address == addr_type'(i));
			assign word_write[i] = write_now && word_hit[i]; // RULE1
			// unaddressed words keep their value
			assign words_after[i] = word_write[i] ? data_in
				: state.words[i];
		end
	endgenerate

	// or-fold keeps the read a plain mux with no priority chain
	generate
		for (genvar k = 0; k < `RS_WORD_COUNT; k++) begin : g_read
			assign word_masked[k] = word_hit[k] ? state.words[k] : '0;
			assign read_fold[k + 1] = read_fold[k] | word_masked[k];
		end
	endgenerate

	assign read_fold[0] = '0;
	assign read_word = read_fold[`RS_WORD_COUNT];

	generate
		for (genvar b = 0; b < `RS_WORD_WIDTH; b++) begin : g_drive
			// drive only while the synced enable pin is low
			assign drive_bits[b] = !drive_n; // RULE7
		end
	endgenerate

	always_comb begin
		next_state = state;
		next_state.cp_prev = cp;
		// writes never touch out_reg, so a held word survives them
		next_state.words = words_after; // RULE1 RULE3 RULE6
		// write needs clock low, load needs a rise: never in one cycle
		if (load_now) begin
			next_state.out_reg = read_word; // RULE4 RULE5 RULE8
		end else begin
			next_state.out_reg = state.out_reg; // RULE5
		end
	end

	// no reset on the part; flops cleared so outputs are defined
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state.words <= {`RS_WORD_COUNT{`RS_WORD_RESET}};
			state.out_reg <= `RS_WORD_RESET;
			state.cp_prev <= 1'h0;
		end else begin
			state <= next_state;
		end
	end

	assign read_data_out_o = state.out_reg;
	assign read_data_oe_o = drive_bits; // RULE7

endmodule : register_stack_16x4
`default_nettype wire

/* hw/register_stack_params.svh */
`ifndef REGISTER_STACK_PARAMS_SVH
`define REGISTER_STACK_PARAMS_SVH

`define RS_WORD_COUNT 16
`define RS_WORD_WIDTH 4
`define RS_ADDR_WIDTH 4
`define RS_SYNC_STAGES 2
`define RS_PIN_COUNT 12
`define RS_WORD_RESET 4'h0

// pin bundle order: address, data, select, write, pin clock, drive enable
`define RS_PIN_ADDR_LSB 8
`define RS_PIN_DATA_LSB 4
`define RS_PIN_SELECT 3
`define RS_PIN_WRITE 2
`define RS_PIN_CLOCK 1
`define RS_PIN_DRIVE 0
// select, write and drive enable idle high, pin clock idle low
`define RS_PIN_IDLE 12'h00D

`endif

/* hw/register_stack_pkg.sv */
`include "register_stack_params.svh"

package register_stack_pkg;

	typedef logic [`RS_WORD_WIDTH-1:0] word_type;
	typedef logic [`RS_ADDR_WIDTH-1:0] addr_type;

	typedef struct packed {
		word_type [`RS_WORD_COUNT-1:0] words;
		word_type out_reg;
		logic cp_prev;
	} stack_state_type;

endpackage : register_stack_pkg

/* hw/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
`include "register_stack_params.svh"

module pin_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// pins in, synchronised out
	input wire logic [`RS_PIN_COUNT-1:0] pins_i,
	output logic [`RS_PIN_COUNT-1:0] pins_o
);

	typedef struct packed {
		logic [`RS_PIN_COUNT-1:0] first;
		logic [`RS_PIN_COUNT-1:0] second;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// first stage feeds only the second stage
	always_comb begin
		next_state.first = pins_i;
		next_state.second = state.first;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// idle levels, so reset can never fake a write or a drive
			state <= {`RS_PIN_IDLE, `RS_PIN_IDLE};
		end else begin
			state <= next_state;
		end
	end

	assign pins_o = state.second;

endmodule : pin_sync
`default_nettype wire

/* sim/register_stack_16x4_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module register_stack_16x4_chk (
	input wire logic clk_i, arst_n_i, chip_select_n_i, write_enable_n_i,
	input wire logic clock_pulse_in_i, output_drive_enable_n_i,
	input wire logic [3:0] read_data_out_o, read_data_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_oe;
		$past(arst_n_i, 2) |->
			read_data_oe_o == {4{!$past(output_drive_enable_n_i, 2)}};
	endproperty
	a_oe: assert property (p_oe) else $error("oe wrong");
	property p_hold;
		$changed(read_data_out_o) |-> !$past(chip_select_n_i, 3) &&
			$past(clock_pulse_in_i, 3) && !$past(clock_pulse_in_i, 4);
	endproperty
	a_hold: assert property (p_hold) else $error("out moved");
	property p_idle_hold;
		!$past(clock_pulse_in_i, 3) |-> $stable(read_data_out_o);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("out moved while pin clock low");
	property p_desel;
		$past(chip_select_n_i, 3) |-> $stable(read_data_out_o);
	endproperty
	a_desel: assert property (p_desel)
		else $error("out moved while deselected");
	property p_write_hold;
		!$past(write_enable_n_i, 3) && !$past(chip_select_n_i, 3) &&
			!$past(clock_pulse_in_i, 3) |-> $stable(read_data_out_o);
	endproperty
	a_write_hold: assert property (p_write_hold)
		else $error("out moved during write");
	property p_single_load;
		$changed(read_data_out_o) |=> $stable(read_data_out_o);
	endproperty
	a_single_load: assert property (p_single_load)
		else $error("out loaded twice for one rise");
endmodule : register_stack_16x4_chk
bind register_stack_16x4 register_stack_16x4_chk i_chk (.*);
`default_nettype wire

/* sim/stack_driver.sv */
`timescale 1ns/10ps
`default_nettype none
module stack_driver (
	input wire logic clk_i,
	output logic [10:0] pin_o = 11'h006
);
	// address, data, select, write, pin clock; phases long for the sync
	task cyc(input logic [10:0] s1, s2);
		pin_o <= s1;
		repeat (3) @(posedge clk_i);
		pin_o <= s2;
		repeat (3) @(posedge clk_i);
		pin_o[2:0] <= 3'h6;
		@(posedge clk_i);
	endtask : cyc
endmodule : stack_driver
`default_nettype wire

/* sim/register_stack_16x4_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module register_stack_16x4_tb;
	import register_stack_pkg::*;
	logic clk_i = 0, arst_n = 0, oe_n = 1, c0 = 0, c;
	logic [2:0] v = 0;
	logic [1:0] ov = 2'h0;
	logic [10:0] p;
	word_type q, z, a, d, mem [16] = '{default: 0}, eq [$];
	int failures = 0, compares = 0, seed = 32'hf8ac;
	initial forever #4 clk_i = ~clk_i;
	stack_driver i_stack_driver (.clk_i, .pin_o(p));
	register_stack_16x4 i_register_stack_16x4 (.clk_i, .arst_n_i(arst_n),
		.word_address_i(p[10:7]), .write_data_in_i(p[6:3]),
		.chip_select_n_i(p[2]), .write_enable_n_i(p[1]),
		.clock_pulse_in_i(p[0]), .output_drive_enable_n_i(oe_n),
		.read_data_out_o(q), .read_data_oe_o(z));
	task chk(input word_type s, e, input string n);
		compares++;
		if (s !== e) failures++;
		if (s !== e) $display("[ERR] %s exp %h saw %h", n, e, s);
	endtask : chk
	task finish_test;
		// a note left unmatched means a read never came back
		if (eq.size() != 0) failures++;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	always @(posedge clk_i) begin
		c0 <= p[0];
		v <= {v[1:0], p[0] & ~c0 & ~p[2]};
		oe_n <= 1'($random(seed));
		// enable pin reaches the drive bits two edges later
		ov <= {ov[0], ~oe_n};
		if (v[2]) begin
			chk(q, eq.pop_front(), "read_data_out");
			chk(z, {4{ov[1]}}, "read_data_oe");
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		arst_n <= 1;
		@(posedge clk_i);
		repeat (60) begin
			{a, d, c} = 9'($random(seed));
			// data moves mid-write, last value must stick
			i_stack_driver.cyc({a, ~d, c, 2'h0}, {a, d, c, 2'h0});
			if (!c) mem[a] = d;
			a = 4'($random(seed));
			eq.push_back(mem[a]);
			i_stack_driver.cyc({a, 4'h0, 3'h2}, {a, 4'h0, 3'h3});
		end
		repeat (4) @(posedge clk_i);
		finish_test();
	end
endmodule : register_stack_16x4_tb
`default_nettype wire
